// >>> afe_control_regs.sv
// Register bank of the battery front end: status, analog select, sleep and
// feature configuration. Host accesses arrive already decoded from the link.
//
// What this block does
// R1: External over-temperature sets status bit 5.
// R2: Internal over-temperature sets status bit 4.
// R3: Flags latch; read clears only if condition gone.
// R4: User flags are plain retained storage.
// R5: Four-bit select routes cells and temperatures.
// R6: Writing sleep bit sleeps, regulator off.
// R7: Sleep bit clears itself on wake.
// R8: Sleep leaves analog select unchanged.
// R9: Auto scan: supply on 5ms per 640ms.
// R10: Feature bit 6 disables regulator.
// R11: Feature bit 5 holds sensor supply on.
// R12: Feature bit 2 clears all registers.
// R13: Feature bit 1 blocks wake pin.
// R14: Feature bit 0 picks wake edge.
// R15: Feature writes need write-enable bit set.
// R16: Sleep cleared by host zero or wake edge.
// R17: Host writes reserved bits as zero.
// R18: Reserved select codes route nothing.
`timescale 1ns/1ps
`default_nettype none
module afe_control_regs #(
    parameter int SCAN_PERIOD = afe_regs_pkg::SCAN_PER_CYC,
    parameter int SCAN_ON     = afe_regs_pkg::SCAN_ON_CYC
) (
    input  wire logic                    clk_sys,
    input  wire logic                    srst,
    input  wire afe_regs_pkg::host_req_t host_req,
    input  wire logic                    ext_overtemp,
    input  wire logic                    int_overtemp,
    input  wire logic                    wake_pin,
    output var  logic [7:0]              rdata,
    output var  logic                    rvalid,
    output var  logic [3:0]              analog_select_field,
    output var  logic                    analog_route_en,
    output var  logic                    sleep_active,
    output var  logic                    regulator_output_en,
    output var  logic                    regulator_disable,
    output var  logic                    sensor_supply_output
);
    typedef struct packed {
        logic       external_overtemp_flag;
        logic       internal_overtemp_flag;
        logic       uflag1;
        logic       uflag0;
        logic [3:0] sel;
        logic       sleep;
        logic       scan_off;
        logic       reg_dis;
        logic       sup_on;
        logic       wake_dis;
        logic       wake_pol;
        logic       fwren;
        logic       wake_prev;
        logic [7:0] rdata;
        logic       rvalid;
        logic       route_en;
        logic       sup_out;
        logic       reg_on;
    } regs_st_t;

    regs_st_t st_r;
    regs_st_t st_nxt;
    logic     scan_win;
    logic     wake_edge;
    logic     sel_ok;
    logic     force_por;
    logic [7:0] rd_mux;

    scan_timer #(
        .PERIOD (SCAN_PERIOD),
        .ON_CYC (SCAN_ON)
    ) u_scan (
        .clk_sys (clk_sys),
        .srst    (srst),
        .run     (!st_r.scan_off && !force_por),                    // R9 R12
        .window  (scan_win)
    );

    always_comb begin
        rd_mux = afe_regs_pkg::RESET_BYTE;
        unique case (host_req.addr)
            afe_regs_pkg::ADDR_IDENT: begin
                rd_mux[afe_regs_pkg::BIT_ID_SINGLE] = 1'b1;
                rd_mux[afe_regs_pkg::BIT_ID_WAKE] =
                    wake_pin ~^ st_r.wake_pol;
            end
            afe_regs_pkg::ADDR_OTSTAT: begin
                rd_mux[afe_regs_pkg::BIT_XOT] = st_r.external_overtemp_flag;
                rd_mux[afe_regs_pkg::BIT_IOT] = st_r.internal_overtemp_flag;
            end
            afe_regs_pkg::ADDR_ANALOG: begin
                rd_mux[afe_regs_pkg::BIT_UFLAG1] = st_r.uflag1;
                rd_mux[afe_regs_pkg::BIT_UFLAG0] = st_r.uflag0;
                rd_mux[3:0] = st_r.sel;
            end
            afe_regs_pkg::ADDR_SLEEP: begin
                rd_mux[afe_regs_pkg::BIT_SLEEP] = st_r.sleep;
            end
            afe_regs_pkg::ADDR_FEATURE: begin
                rd_mux[afe_regs_pkg::BIT_SCANOFF] = st_r.scan_off;
                rd_mux[afe_regs_pkg::BIT_REGDIS] = st_r.reg_dis;
                rd_mux[afe_regs_pkg::BIT_SUPON] = st_r.sup_on;
                rd_mux[afe_regs_pkg::BIT_WAKEDIS] = st_r.wake_dis;
                rd_mux[afe_regs_pkg::BIT_WAKEPOL] = st_r.wake_pol;
            end
            afe_regs_pkg::ADDR_WREN: begin
                rd_mux[afe_regs_pkg::BIT_FWREN] = st_r.fwren;
            end
            default: begin
                rd_mux = afe_regs_pkg::RESET_BYTE;
            end
        endcase
    end

    always_comb begin
        st_nxt = st_r;
        wake_edge = (st_r.wake_pol ? (wake_pin && !st_r.wake_prev)  // R14
                                   : (!wake_pin && st_r.wake_prev))
                    && !st_r.wake_dis;                              // R13
        force_por = host_req.wr
            && host_req.addr == afe_regs_pkg::ADDR_FEATURE
            && st_r.fwren
            && host_req.wdata[afe_regs_pkg::BIT_FPOR];
        st_nxt.wake_prev = wake_pin;
        st_nxt.rvalid = host_req.rd;
        st_nxt.rdata = host_req.rd ? rd_mux : st_r.rdata;
        // Read clears a flag only if its condition is gone; set wins.
        if (host_req.rd && host_req.addr == afe_regs_pkg::ADDR_OTSTAT) begin
            st_nxt.external_overtemp_flag = 1'b0;                                      // R3
            st_nxt.internal_overtemp_flag = 1'b0;                                      // R3
        end
        if (ext_overtemp) begin
            st_nxt.external_overtemp_flag = 1'b1;                                      // R1
        end
        if (int_overtemp) begin
            st_nxt.internal_overtemp_flag = 1'b1;                                      // R2
        end
        if (host_req.wr) begin
            unique case (host_req.addr)
                afe_regs_pkg::ADDR_ANALOG: begin
                    st_nxt.uflag1 =
                        host_req.wdata[afe_regs_pkg::BIT_UFLAG1];   // R4
                    st_nxt.uflag0 =
                        host_req.wdata[afe_regs_pkg::BIT_UFLAG0];   // R4
                    st_nxt.sel = host_req.wdata[3:0];
                end
                afe_regs_pkg::ADDR_SLEEP: begin
                    st_nxt.sleep =
                        host_req.wdata[afe_regs_pkg::BIT_SLEEP];    // R6 R16
                end
                afe_regs_pkg::ADDR_FEATURE: begin
                    if (st_r.fwren) begin                           // R15
                        st_nxt.scan_off =
                            host_req.wdata[afe_regs_pkg::BIT_SCANOFF];
                        st_nxt.reg_dis =
                            host_req.wdata[afe_regs_pkg::BIT_REGDIS]; // R10
                        st_nxt.sup_on =
                            host_req.wdata[afe_regs_pkg::BIT_SUPON];  // R11
                        st_nxt.wake_dis =
                            host_req.wdata[afe_regs_pkg::BIT_WAKEDIS];
                        st_nxt.wake_pol =
                            host_req.wdata[afe_regs_pkg::BIT_WAKEPOL];
                    end
                end
                afe_regs_pkg::ADDR_WREN: begin
                    st_nxt.fwren = host_req.wdata[afe_regs_pkg::BIT_FWREN];
                end
                default: begin
                    st_nxt.fwren = st_r.fwren;
                end
            endcase
        end
        if (st_r.sleep && wake_edge) begin
            st_nxt.sleep = 1'b0;                                    // R7 R16
        end
        // Analog select is untouched by sleep entry.                  R8
        sel_ok = (st_nxt.sel <= afe_regs_pkg::SEL_INT_TEMP);        // R18
        st_nxt.route_en = sel_ok
            && st_nxt.sel != afe_regs_pkg::SEL_NONE;                // R5
        st_nxt.sup_out = st_nxt.sup_on                              // R11
            || (scan_win && !st_nxt.scan_off)                       // R9
            || st_nxt.sel == afe_regs_pkg::SEL_EXT_TEMP;
        if (force_por) begin
            st_nxt = '0;                                            // R12
            st_nxt.wake_prev = wake_pin;
        end
        st_nxt.reg_on = !st_nxt.sleep && !st_nxt.reg_dis;           // R6 R10
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign rdata                = st_r.rdata;
    assign rvalid               = st_r.rvalid;
    assign analog_select_field  = st_r.sel;
    assign analog_route_en      = st_r.route_en;
    assign sleep_active         = st_r.sleep;
    assign regulator_output_en  = st_r.reg_on;
    assign regulator_disable    = st_r.reg_dis;
    assign sensor_supply_output = st_r.sup_out;

    property p_xot_set;
        @(posedge clk_sys) disable iff (srst)
        ext_overtemp && !force_por |=> st_r.external_overtemp_flag;
    endproperty
    a_xot_set: assert property (p_xot_set) else $error("xot not set"); // R1

    property p_iot_set;
        @(posedge clk_sys) disable iff (srst)
        int_overtemp && !force_por |=> st_r.internal_overtemp_flag;
    endproperty
    a_iot_set: assert property (p_iot_set) else $error("iot not set"); // R2

    property p_clear_read;
        @(posedge clk_sys) disable iff (srst)
        host_req.rd && host_req.addr == afe_regs_pkg::ADDR_OTSTAT
            && !ext_overtemp |=> !st_r.external_overtemp_flag;
    endproperty
    a_clear_read: assert property (p_clear_read) // R3
        else $error("xot not cleared by read");

    property p_hold;
        @(posedge clk_sys) disable iff (srst)
        st_r.external_overtemp_flag && !host_req.rd && !force_por |=> st_r.external_overtemp_flag;
    endproperty
    a_hold: assert property (p_hold) else $error("xot dropped"); // R3

    property p_sleep_reg;
        @(posedge clk_sys) disable iff (srst)
        sleep_active |-> !regulator_output_en;
    endproperty
    a_sleep_reg: assert property (p_sleep_reg) // R6
        else $error("regulator on in sleep");

    property p_sel_keep;
        @(posedge clk_sys) disable iff (srst)
        $rose(sleep_active) |-> $stable(analog_select_field);
    endproperty
    a_sel_keep: assert property (p_sel_keep) // R8
        else $error("select changed on sleep");

    sequence s_supon_held;
        st_r.sup_on ##1 st_r.sup_on;
    endsequence

    property p_supon;
        @(posedge clk_sys) disable iff (srst)
        s_supon_held |-> sensor_supply_output;
    endproperty
    a_supon: assert property (p_supon) else $error("supply not on"); // R11

    property p_wren;
        @(posedge clk_sys) disable iff (srst)
        host_req.wr && host_req.addr == afe_regs_pkg::ADDR_FEATURE
            && !st_r.fwren |=> $stable(st_r.wake_pol);
    endproperty
    a_wren: assert property (p_wren) else $error("locked write took"); // R15

    property p_reserved;
        @(posedge clk_sys) disable iff (srst)
        analog_select_field > afe_regs_pkg::SEL_INT_TEMP
            |-> !analog_route_en;
    endproperty
    a_reserved: assert property (p_reserved) // R18
        else $error("reserved code routed");

    property p_iot_clear;
        @(posedge clk_sys) disable iff (srst)
        host_req.rd && host_req.addr == afe_regs_pkg::ADDR_OTSTAT
            && !int_overtemp |=> !st_r.internal_overtemp_flag;
    endproperty
    a_iot_clear: assert property (p_iot_clear) else $error("iot kept"); // R3

    property p_por;
        @(posedge clk_sys) disable iff (srst)
        force_por |=> analog_select_field == afe_regs_pkg::SEL_NONE
            && !sleep_active && !regulator_disable && !st_r.fwren;
    endproperty
    a_por: assert property (p_por) else $error("forced reset missed"); // R12

    property p_wake;
        @(posedge clk_sys) disable iff (srst)
        st_r.sleep && wake_edge |=> !sleep_active;
    endproperty
    a_wake: assert property (p_wake) else $error("wake edge ignored"); // R7

    sequence s_locked_asleep;
        st_r.sleep && st_r.wake_dis && !force_por;
    endsequence

    sequence s_no_sleep_write;
        !(host_req.wr && host_req.addr == afe_regs_pkg::ADDR_SLEEP);
    endsequence

    property p_wake_locked;
        @(posedge clk_sys) disable iff (srst)
        s_locked_asleep ##0 s_no_sleep_write |=> sleep_active;
    endproperty
    a_wake_locked: assert property (p_wake_locked) // R13
        else $error("woke with wake pin disabled");

    property p_regdis;
        @(posedge clk_sys) disable iff (srst)
        regulator_disable |-> !regulator_output_en;
    endproperty
    a_regdis: assert property (p_regdis) else $error("regulator on"); // R10

    property p_scan_quiet;
        @(posedge clk_sys) disable iff (srst)
        st_r.scan_off && !st_r.sup_on && !host_req.wr
            && st_r.sel != afe_regs_pkg::SEL_EXT_TEMP
            |=> !sensor_supply_output;
    endproperty
    a_scan_quiet: assert property (p_scan_quiet) // R9
        else $error("supply on with scan off");
endmodule // afe_control_regs
`default_nettype wire

// >>> afe_regs_pkg.sv
// Package: register map, field positions and timing for the front-end bank.
// Assumes a 125 MHz system clock.
`default_nettype none
package afe_regs_pkg;

    localparam logic [7:0] ADDR_IDENT    = 8'h00;
    localparam logic [7:0] ADDR_OTSTAT   = 8'h01;
    localparam logic [7:0] ADDR_ANALOG   = 8'h03;
    localparam logic [7:0] ADDR_SLEEP    = 8'h04;
    localparam logic [7:0] ADDR_FEATURE  = 8'h07;
    localparam logic [7:0] ADDR_WREN     = 8'h08;

    localparam int BIT_XOT       = 5;
    localparam int BIT_IOT       = 4;
    localparam int BIT_UFLAG1    = 7;
    localparam int BIT_UFLAG0    = 6;
    localparam int BIT_SLEEP     = 7;
    localparam int BIT_SCANOFF   = 7;
    localparam int BIT_REGDIS    = 6;
    localparam int BIT_SUPON     = 5;
    localparam int BIT_FPOR      = 2;
    localparam int BIT_WAKEDIS   = 1;
    localparam int BIT_WAKEPOL   = 0;
    localparam int BIT_FWREN     = 7;
    localparam int BIT_ID_SINGLE = 5;
    localparam int BIT_ID_WAKE   = 4;

    localparam logic [3:0] SEL_NONE     = 4'h0;
    localparam logic [3:0] SEL_EXT_TEMP = 4'h8;
    localparam logic [3:0] SEL_INT_TEMP = 4'h9;

    localparam logic [7:0] RESET_BYTE = 8'h00;

    localparam int CLK_HZ        = 125_000_000;
    localparam int SCAN_ON_MS    = 5;
    localparam int SCAN_PERIOD_MS = 640;
    localparam int SCAN_ON_CYC   = CLK_HZ / 1000 * SCAN_ON_MS;
    localparam int SCAN_PER_CYC  = CLK_HZ / 1000 * SCAN_PERIOD_MS;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } host_req_t;

endpackage
`default_nettype wire

// >>> scan_timer.sv
// Periodic temperature-scan timer: on for a window at the start of each
// period. Assumes synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module scan_timer #(
    parameter int PERIOD = afe_regs_pkg::SCAN_PER_CYC,
    parameter int ON_CYC = afe_regs_pkg::SCAN_ON_CYC
) (
    input  wire logic clk_sys,
    input  wire logic srst,
    input  wire logic run,
    output var  logic window
);
    typedef struct packed {
        logic [31:0] cnt;
        logic        win;
    } tmr_st_t;

    tmr_st_t st_r;
    tmr_st_t st_nxt;

    always_comb begin
        st_nxt = st_r;
        if (!run) begin
            st_nxt.cnt = 32'h0;
            st_nxt.win = 1'b0;
        end else begin
            if (st_r.cnt >= 32'(PERIOD - 1)) begin
                st_nxt.cnt = 32'h0;
            end else begin
                st_nxt.cnt = st_r.cnt + 32'h1;
            end
            st_nxt.win = (st_nxt.cnt < 32'(ON_CYC));
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign window = st_r.win;
endmodule // scan_timer
`default_nettype wire

// >>> afe_host_model.sv
// Host model: issues single-byte register reads and writes to the bank.
// Assumes strobes are taken on the rising edge of clk_sys.
`timescale 1ns/1ps
`default_nettype none
module afe_host_model (
    input  wire logic                    clk_sys,
    input  wire logic [7:0]              rdata,
    input  wire logic                    rvalid,
    output var  afe_regs_pkg::host_req_t host_req
);
    initial host_req = '0;

    // Released address and data show the inverse, never the last value.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_sys);
        host_req.wr    = 1'b1;
        host_req.addr  = a;
        host_req.wdata = d;
        @(negedge clk_sys);
        host_req.wr    = 1'b0;
        host_req.addr  = ~a;
        host_req.wdata = ~d;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        d = 8'hxx;
        @(negedge clk_sys);
        host_req.rd   = 1'b1;
        host_req.addr = a;
        @(negedge clk_sys);
        host_req.rd   = 1'b0;
        host_req.addr = ~a;
        for (int i = 0; i < 4; i++) begin
            if (rvalid === 1'b1) begin
                d = rdata;
                break;
            end
            @(negedge clk_sys);
        end
    endtask
endmodule // afe_host_model
`default_nettype wire

// >>> test_battery_afe_control_registers.sv
// Testbench of the front-end register bank, driven through the host model.
// Assumes a shortened scan of 5 cycles on in every 64.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin n_errors++; \
    $display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); end end
module test_battery_afe_control_registers;
    logic                    clk_sys;
    logic                    srst;
    logic                    ext_ot;
    logic                    int_ot;
    logic                    wake_pin;
    afe_regs_pkg::host_req_t host_req;
    logic [7:0]              rdata;
    logic                    rvalid;
    logic [3:0]              sel;
    logic                    route_en;
    logic                    sleep_active;
    logic                    reg_out_en;
    logic                    reg_dis;
    logic                    sup_out;
    int                      n_errors = 0;
    int                      checks = 0;
    int                      cyc = 0;
    logic [7:0]              cnt;
    logic [7:0]              fcfg [3] = '{8'h80, 8'h81, 8'h82};
    logic                    p0 [3] = '{1'b1, 1'b0, 1'b1};
    logic                    slp [3] = '{1'b0, 1'b0, 1'b1};

    afe_control_regs #(.SCAN_PERIOD(64), .SCAN_ON(5)) dut_u (
        .clk_sys(clk_sys), .srst(srst), .host_req(host_req),
        .ext_overtemp(ext_ot), .int_overtemp(int_ot), .wake_pin(wake_pin),
        .rdata(rdata), .rvalid(rvalid), .analog_select_field(sel),
        .analog_route_en(route_en), .sleep_active(sleep_active),
        .regulator_output_en(reg_out_en), .regulator_disable(reg_dis),
        .sensor_supply_output(sup_out)
    );

    afe_host_model host_u (
        .clk_sys(clk_sys), .rdata(rdata), .rvalid(rvalid),
        .host_req(host_req)
    );

    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end

    task automatic give_verdict;
        $display("errors=%0d checks=%0d", n_errors, checks);
        if (n_errors == 0 && checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic rchk(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] g;
        host_u.rd(a, g);
        `CHK(g, e)
    endtask

    task automatic hold(input int c);
        repeat (c) @(negedge clk_sys);
    endtask

    task automatic count(input int c);
        cnt = 8'h00;
        repeat (c) begin
            @(negedge clk_sys);
            cnt = cnt + {7'h00, sup_out};
        end
    endtask

    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            n_errors++;
            give_verdict();
        end
    end

    initial begin
        srst = 1'b1;
        ext_ot = 1'b0;
        int_ot = 1'b0;
        wake_pin = 1'b1;
        hold(6);
        srst = 1'b0;
        `CHK(sleep_active, 1'b0)
        rchk(afe_regs_pkg::ADDR_OTSTAT, 8'h00);
        rchk(afe_regs_pkg::ADDR_ANALOG, 8'h00);
        rchk(afe_regs_pkg::ADDR_SLEEP, 8'h00);
        rchk(afe_regs_pkg::ADDR_FEATURE, 8'h00);
        rchk(afe_regs_pkg::ADDR_WREN, 8'h00);
        rchk(afe_regs_pkg::ADDR_IDENT, 8'h20);
        host_u.wr(8'h02, 8'h00);
        `CHK(rvalid, 1'b0)
        rchk(8'h02, 8'h00);
        count(128);
        `CHK(cnt, 8'd10)
        host_u.wr(afe_regs_pkg::ADDR_FEATURE, 8'h80);
        rchk(afe_regs_pkg::ADDR_FEATURE, 8'h00);
        host_u.wr(afe_regs_pkg::ADDR_WREN, 8'h80);
        host_u.wr(afe_regs_pkg::ADDR_FEATURE, 8'h80);
        rchk(afe_regs_pkg::ADDR_FEATURE, 8'h80);
        count(128);
        `CHK(cnt, 8'd0)
        host_u.wr(afe_regs_pkg::ADDR_FEATURE, 8'ha0);
        count(70);
        `CHK(cnt, 8'd70)
        host_u.wr(afe_regs_pkg::ADDR_FEATURE, 8'hc0);
        `CHK(reg_dis, 1'b1)
        `CHK(reg_out_en, 1'b0)
        host_u.wr(afe_regs_pkg::ADDR_FEATURE, 8'h80);
        `CHK(reg_out_en, 1'b1)
        for (logic [4:0] i = 0; i < 16; i++) begin
            host_u.wr(afe_regs_pkg::ADDR_ANALOG, {i[1:0], 2'b00, i[3:0]});
            rchk(afe_regs_pkg::ADDR_ANALOG, {i[1:0], 2'b00, i[3:0]});
            `CHK(sel, i[3:0])
            `CHK(route_en, (i >= 1 && i <= 9))
            `CHK(sup_out, (i == 8))
        end
        host_u.wr(afe_regs_pkg::ADDR_ANALOG, 8'h45);
        host_u.wr(afe_regs_pkg::ADDR_SLEEP, 8'h80);
        `CHK(sleep_active, 1'b1)
        `CHK(reg_out_en, 1'b0)
        `CHK(sel, 4'h5)
        rchk(afe_regs_pkg::ADDR_ANALOG, 8'h45);
        host_u.wr(afe_regs_pkg::ADDR_SLEEP, 8'h00);
        `CHK(sleep_active, 1'b0)
        for (int k = 0; k < 3; k++) begin
            wake_pin = p0[k];
            hold(2);
            host_u.wr(afe_regs_pkg::ADDR_FEATURE, fcfg[k]);
            host_u.wr(afe_regs_pkg::ADDR_SLEEP, 8'h80);
            `CHK(sleep_active, 1'b1)
            wake_pin = ~p0[k];
            hold(3);
            `CHK(sleep_active, slp[k])
            rchk(afe_regs_pkg::ADDR_SLEEP, {slp[k], 7'h00});
            host_u.wr(afe_regs_pkg::ADDR_SLEEP, 8'h00);
        end
        ext_ot = 1'b1;
        hold(2);
        ext_ot = 1'b0;
        hold(2);
        rchk(afe_regs_pkg::ADDR_OTSTAT, 8'h20);
        rchk(afe_regs_pkg::ADDR_OTSTAT, 8'h00);
        int_ot = 1'b1;
        hold(2);
        rchk(afe_regs_pkg::ADDR_OTSTAT, 8'h10);
        rchk(afe_regs_pkg::ADDR_OTSTAT, 8'h10);
        int_ot = 1'b0;
        hold(2);
        rchk(afe_regs_pkg::ADDR_OTSTAT, 8'h10);
        rchk(afe_regs_pkg::ADDR_OTSTAT, 8'h00);
        ext_ot = 1'b1;
        int_ot = 1'b1;
        hold(2);
        ext_ot = 1'b0;
        int_ot = 1'b0;
        rchk(afe_regs_pkg::ADDR_OTSTAT, 8'h30);
        host_u.wr(afe_regs_pkg::ADDR_ANALOG, 8'hc3);
        `CHK(sel, 4'h3)
        host_u.wr(afe_regs_pkg::ADDR_FEATURE, 8'h84);
        hold(2);
        `CHK(sel, 4'h0)
        rchk(afe_regs_pkg::ADDR_ANALOG, 8'h00);
        rchk(afe_regs_pkg::ADDR_WREN, 8'h00);
        rchk(afe_regs_pkg::ADDR_FEATURE, 8'h00);
        give_verdict();
    end
endmodule // test_battery_afe_control_registers
`default_nettype wire
